// *** logic/copper_phy_regs.svh ***
// offsets, field positions, reset values of the copper status block
// assumes an 8-bit byte address on the register bus
`ifndef COPPER_PHY_REGS_SVH
`define COPPER_PHY_REGS_SVH

`define PHY_ADDR_W 8
`define PHY_REG_W 16
`define PHY_CTRL_IDX 6'h10
`define PHY_STAT1_IDX 6'h11
`define PHY_IEN_IDX 6'h12
`define PHY_EVT_IDX 6'h13
`define PHY_CTRL_ADDR {`PHY_CTRL_IDX, 2'h0}
`define PHY_STAT1_ADDR {`PHY_STAT1_IDX, 2'h0}
`define PHY_IEN_ADDR {`PHY_IEN_IDX, 2'h0}
`define PHY_EVT_ADDR {`PHY_EVT_IDX, 2'h0}

// control register fields
`define CTRL_SWRST 15
`define CTRL_AN_EN 12
`define CTRL_MDI_HI 6
`define CTRL_MDI_LO 5
`define CTRL_POL_DIS 1

// status fields
`define ST_SPEED_HI 15
`define ST_SPEED_LO 14
`define ST_DUPLEX 13
`define ST_PAGE 12
`define ST_RESOLVED 11
`define ST_LINK_RT 10
`define ST_TX_PAUSE 9
`define ST_RX_PAUSE 8
`define ST_MDIX 6
`define ST_DOWNSHIFT 5
`define ST_ENERGY 4
`define ST_LINK 3
`define ST_POL 1
`define ST_JABBER 0

// event and enable bit positions
`define EV_AN_ERR 15
`define EV_SPEED 14
`define EV_DUPLEX 13
`define EV_PAGE 12
`define EV_AN_DONE 11
`define EV_LINK 10
`define EV_SYMBOL 9
`define EV_FALSE_CAR 8
`define EV_MDIX 6
`define EV_DOWNSHIFT 5
`define EV_ENERGY 4
`define EV_FLP_NOLINK 3
`define EV_POL 1
`define EV_JABBER 0

`define EV_VALID_MASK 16'hFF7B
`define RST_SPEED 2'h2
`define RST_MDIX 1'h1
`define RST_MDI_MODE 2'h3
`define RST_AN_EN 1'h1
`define RST_IEN 16'h0000

`endif

// *** logic/copper_phy_pkg.sv ***
// types of the copper status block
// assumes copper_phy_regs.svh for all numbers
package copper_phy_pkg;

	typedef enum logic [1:0]
	{
		MDI_MANUAL = 2'h0,
		MDIX_MANUAL = 2'h1,
		MDI_RSVD = 2'h2,
		MDI_AUTO = 2'h3
	} mdi_mode_t;

	typedef enum logic [2:0]
	{
		SEL_NONE = 3'h0,
		SEL_CTRL = 3'h1,
		SEL_STAT1 = 3'h2,
		SEL_IEN = 3'h3,
		SEL_EVT = 3'h4
	} reg_sel_t;

	typedef struct packed {
		logic [15:0] ien;
		logic an_en;
		logic [1:0] mdi_mode;
		logic [1:0] mdi_act;
		logic pol_dis;
		logic [15:0] stat;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
	} phy_state_t;

	typedef struct packed {
		logic [15:0] q;
	} evt_state_t;

endpackage : copper_phy_pkg

// *** logic/copper_event_latch.sv ***
// latched-high event bits, cleared by read or by writing ones
// assumes set pulses already aligned to pclk
`timescale 1ns/1ps
`default_nettype none
`include "copper_phy_regs.svh"

module copper_event_latch #(
	parameter logic [15:0] VALID = `EV_VALID_MASK
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [15:0] set,
	input wire logic rd_clr,
	input wire logic [15:0] w1c,
	input wire logic sw_clr,
	output logic [15:0] q
);

	copper_phy_pkg::evt_state_t st;
	copper_phy_pkg::evt_state_t next_st;
	logic [15:0] clr;

	always_comb
	begin
		clr = w1c | {16{rd_clr | sw_clr}};
		// set beats a clear landing in the same cycle
		next_st.q = ((st.q & ~clr) | set) & VALID;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign q = st.q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	set_wins_a: assert property (|set |=> |(q & $past(set)))
		else $error("event set lost against clear");
	read_clear_a: assert property (
		(rd_clr && set == 16'h0000) |=> q == 16'h0000)
		else $error("read did not clear idle events");
	rsv_zero_a: assert property ((q & ~VALID) == 16'h0000)
		else $error("reserved event bit set");

endmodule : copper_event_latch
`default_nettype wire

// *** logic/copper_phy_status_irq_enable.sv ***
// copper status, event and interrupt-enable registers on APB
// assumes PHY datapath inputs are synchronous to pclk
`timescale 1ns/1ps
`default_nettype none
`include "copper_phy_regs.svh"

module copper_phy_status_irq_enable #(
	parameter int ADDR_W = `PHY_ADDR_W
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic an_complete,
	input wire logic [1:0] line_speed,
	input wire logic line_full_duplex,
	input wire logic page_in,
	input wire logic link_up,
	input wire logic tx_pause_in,
	input wire logic rx_pause_in,
	input wire logic auto_mdix,
	input wire logic downshift_in,
	input wire logic energy_sleep,
	input wire logic polarity_rev,
	input wire logic jabber_in,
	input wire logic ms_fault,
	input wire logic pd_fault,
	input wire logic no_common_mode,
	input wire logic an_no_link,
	input wire logic symbol_err,
	input wire logic false_carrier,
	input wire logic flp_no_link,
	output logic [1:0] mdi_mode_active,
	output logic polarity_detect_off
);

	copper_phy_pkg::phy_state_t st;
	copper_phy_pkg::phy_state_t next_st;
	logic [15:0] ev_q;
	logic [15:0] ev_set;
	logic [15:0] ev_w1c;
	logic ev_rd_clr;
	logic sw_go;
	logic acc;
	logic setup;
	logic low_lanes;
	logic resolved;
	logic [15:0] s;
	copper_phy_pkg::reg_sel_t sel_setup;
	copper_phy_pkg::reg_sel_t sel_acc;

	function automatic copper_phy_pkg::reg_sel_t decode(
		input logic [ADDR_W-1:0] a);
		if (a == ADDR_W'(`PHY_CTRL_ADDR))
			return copper_phy_pkg::SEL_CTRL;
		else if (a == ADDR_W'(`PHY_STAT1_ADDR))
			return copper_phy_pkg::SEL_STAT1;
		else if (a == ADDR_W'(`PHY_IEN_ADDR))
			return copper_phy_pkg::SEL_IEN;
		else if (a == ADDR_W'(`PHY_EVT_ADDR))
			return copper_phy_pkg::SEL_EVT;
		else
			return copper_phy_pkg::SEL_NONE;
	endfunction : decode

	// crossover bit from the mode taken at the last soft reset
	function automatic logic mdix_of(input logic [1:0] mode,
		input logic auto_in);
		if (mode == 2'(copper_phy_pkg::MDI_MANUAL))
			return 1'b0;
		else if (mode == 2'(copper_phy_pkg::MDIX_MANUAL))
			return 1'b1;
		else
			return auto_in;
	endfunction : mdix_of

	copper_event_latch #(
		.VALID(`EV_VALID_MASK)
	) u_events (
		.pclk(pclk),
		.presetn(presetn),
		.set(ev_set),
		.rd_clr(ev_rd_clr),
		.w1c(ev_w1c),
		.sw_clr(sw_go),
		.q(ev_q)
	);

	always_comb
	begin
		next_st = st;
		s = st.stat;
		setup = psel && !penable;
		acc = psel && penable && st.pready;
		// only the low two lanes carry the 16-bit registers
		low_lanes = pstrb[1] && pstrb[0];
		sel_setup = decode(paddr);
		sel_acc = decode(paddr);
		sw_go = acc && pwrite && low_lanes &&
			sel_acc == copper_phy_pkg::SEL_CTRL && pwdata[`CTRL_SWRST];
		ev_w1c = '0;
		ev_rd_clr = acc && !pwrite && sel_acc == copper_phy_pkg::SEL_EVT;

		resolved = !st.an_en || an_complete;
		s[`ST_RESOLVED] = resolved;
		if (resolved)
			s[`ST_SPEED_HI:`ST_SPEED_LO] = line_speed;
		if (resolved)
			s[`ST_DUPLEX] = line_full_duplex;
		if (resolved)
		begin
			s[`ST_TX_PAUSE] = tx_pause_in;
			s[`ST_RX_PAUSE] = rx_pause_in;
		end
		if (resolved)
			s[`ST_MDIX] = mdix_of(st.mdi_act, auto_mdix);
		s[`ST_LINK_RT] = link_up;
		s[`ST_LINK] = link_up;
		s[`ST_POL] = polarity_rev && !st.pol_dis;
		s[`ST_DOWNSHIFT] = downshift_in;
		s[`ST_ENERGY] = energy_sleep;
		s[`ST_JABBER] = jabber_in;
		// status read clears page unless still arriving
		if (acc && !pwrite && sel_acc == copper_phy_pkg::SEL_STAT1)
			s[`ST_PAGE] = 1'b0;
		if (page_in)
			s[`ST_PAGE] = 1'b1;
		s[7] = 1'b0;
		s[2] = 1'b0;

		ev_set = '0;
		ev_set[`EV_AN_ERR] = ms_fault || pd_fault || no_common_mode ||
			an_no_link;
		ev_set[`EV_SPEED] = s[`ST_SPEED_HI:`ST_SPEED_LO] !=
			st.stat[`ST_SPEED_HI:`ST_SPEED_LO];
		ev_set[`EV_DUPLEX] = s[`ST_DUPLEX] != st.stat[`ST_DUPLEX];
		ev_set[`EV_PAGE] = page_in;
		ev_set[`EV_AN_DONE] = an_complete && st.an_en &&
			!st.stat[`ST_RESOLVED];
		ev_set[`EV_LINK] = s[`ST_LINK] != st.stat[`ST_LINK];
		ev_set[`EV_SYMBOL] = symbol_err;
		ev_set[`EV_FALSE_CAR] = false_carrier;
		ev_set[`EV_MDIX] = s[`ST_MDIX] != st.stat[`ST_MDIX];
		ev_set[`EV_DOWNSHIFT] = s[`ST_DOWNSHIFT] &&
			!st.stat[`ST_DOWNSHIFT];
		ev_set[`EV_ENERGY] = s[`ST_ENERGY] != st.stat[`ST_ENERGY];
		ev_set[`EV_FLP_NOLINK] = flp_no_link;
		ev_set[`EV_POL] = s[`ST_POL] != st.stat[`ST_POL];
		ev_set[`EV_JABBER] = s[`ST_JABBER] && !st.stat[`ST_JABBER];

		// soft reset clears page, and clears resolved when negotiation is on
		if (sw_go)
		begin
			s[`ST_PAGE] = 1'b0;
			// negotiation off keeps resolved at one
			s[`ST_RESOLVED] = !st.an_en;
			next_st.mdi_act = st.mdi_mode;
		end
		next_st.stat = s;

		// zero-wait slave: decode in setup, answer in access
		next_st.pready = setup;
		if (setup)
		begin
			next_st.pslverr = sel_setup == copper_phy_pkg::SEL_NONE;
			next_st.prdata = '0;
			if (!pwrite)
			begin
				if (sel_setup == copper_phy_pkg::SEL_CTRL)
				begin
					next_st.prdata[`CTRL_AN_EN] = st.an_en;
					next_st.prdata[`CTRL_MDI_HI:`CTRL_MDI_LO] =
						st.mdi_mode;
					next_st.prdata[`CTRL_POL_DIS] = st.pol_dis;
				end
				else if (sel_setup == copper_phy_pkg::SEL_STAT1)
					next_st.prdata[15:0] = st.stat;
				else if (sel_setup == copper_phy_pkg::SEL_IEN)
					next_st.prdata[15:0] = st.ien;
				else if (sel_setup == copper_phy_pkg::SEL_EVT)
					next_st.prdata[15:0] = ev_q;
			end
		end
		else
		begin
			next_st.pslverr = 1'b0;
		end

		if (acc && pwrite && low_lanes)
		begin
			if (sel_acc == copper_phy_pkg::SEL_CTRL)
			begin
				next_st.an_en = pwdata[`CTRL_AN_EN];
				// new crossover mode waits for a soft reset
				next_st.mdi_mode = pwdata[`CTRL_MDI_HI:`CTRL_MDI_LO];
				next_st.pol_dis = pwdata[`CTRL_POL_DIS];
				if (pwdata[`CTRL_SWRST])
					next_st.mdi_act =
						pwdata[`CTRL_MDI_HI:`CTRL_MDI_LO];
			end
			else if (sel_acc == copper_phy_pkg::SEL_IEN)
				next_st.ien = pwdata[15:0] & `EV_VALID_MASK;
			else if (sel_acc == copper_phy_pkg::SEL_EVT)
				ev_w1c = pwdata[15:0];
		end

		// level interrupt, one cycle behind the latch
		next_st.irq = |(ev_q & st.ien);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= '0;
			st.ien <= `RST_IEN;
			st.an_en <= `RST_AN_EN;
			st.mdi_mode <= `RST_MDI_MODE;
			st.mdi_act <= `RST_MDI_MODE;
			st.stat[`ST_SPEED_HI:`ST_SPEED_LO] <= `RST_SPEED;
			st.stat[`ST_MDIX] <= `RST_MDIX;
		end
		else
			st <= next_st;
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign irq = st.irq;
	assign mdi_mode_active = st.mdi_act;
	assign polarity_detect_off = st.pol_dis;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence ien_write_s;
		acc && pwrite && low_lanes && sel_acc == copper_phy_pkg::SEL_IEN;
	endsequence

	sequence swrst_s;
		sw_go;
	endsequence

	sequence stat_read_s;
		acc && !pwrite && sel_acc == copper_phy_pkg::SEL_STAT1;
	endsequence

	stat_rsv_zero_a: assert property (st.stat[7] == 1'b0 && st.stat[2] == 1'b0)
		else $error("reserved status bit set");
	resolved_an_off_a: assert property (!st.an_en |=> st.stat[`ST_RESOLVED])
		else $error("resolved low with negotiation off");
	speed_hold_a: assert property (!resolved |=> $stable(st.stat[15:14]))
		else $error("speed moved while unresolved");
	page_latch_a: assert property (page_in && !sw_go |=> st.stat[`ST_PAGE])
		else $error("page received not latched");
	page_swrst_a: assert property ((swrst_s and !page_in) |=>
		!st.stat[`ST_PAGE])
		else $error("page not cleared by soft reset");
	ien_keep_a: assert property (swrst_s ##0
		!(acc && pwrite && sel_acc == copper_phy_pkg::SEL_IEN) |=>
		$stable(st.ien))
		else $error("enables lost on soft reset");
	ien_write_a: assert property (ien_write_s |=>
		st.ien == ($past(pwdata[15:0]) & 16'hFF7B))
		else $error("enable write not stored");
	irq_level_a: assert property (##1 irq == |($past(ev_q) & $past(st.ien)))
		else $error("interrupt does not match events");
	manual_mdix_a: assert property (resolved && st.mdi_act == 2'h1 |=> st.stat[`ST_MDIX])
		else $error("manual MDI-X not reported");
	pol_off_a: assert property (st.pol_dis |=> !st.stat[`ST_POL])
		else $error("polarity reversed while detection off");
	link_a: assert property (##1
		st.stat[`ST_LINK] == $past(link_up) &&
		st.stat[`ST_LINK_RT] == $past(link_up))
		else $error("link bits do not follow link");
	an_err_a: assert property ((ms_fault || no_common_mode) |=> ev_q[`EV_AN_ERR])
		else $error("negotiation error not flagged");
	answer_a: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("bus answer not one cycle");
	unmapped_a: assert property (psel && !penable &&
		decode(paddr) == copper_phy_pkg::SEL_NONE |=> pslverr)
		else $error("unmapped address not refused");
	dup_hold_a: assert property (!resolved |=> $stable(st.stat[13]))
		else $error("duplex moved while unresolved");
	pause_hold_a: assert property (!resolved |=> $stable(st.stat[9:8]))
		else $error("pause bits moved while unresolved");
	speed_follow_a: assert property (resolved |=>
		st.stat[15:14] == $past(line_speed))
		else $error("speed field does not follow result");
	duplex_follow_a: assert property (resolved |=>
		st.stat[13] == $past(line_full_duplex))
		else $error("duplex bit does not follow result");
	resolved_set_a: assert property (an_complete && !sw_go |=>
		st.stat[`ST_RESOLVED])
		else $error("resolved flag not set on completion");
	ds_follow_a: assert property (##1
		st.stat[5] == $past(downshift_in) &&
		st.stat[4] == $past(energy_sleep) && st.stat[0] == $past(jabber_in))
		else $error("downshift energy jabber bits stale");
	pol_follow_a: assert property (!st.pol_dis |=>
		st.stat[`ST_POL] == $past(polarity_rev))
		else $error("polarity bit does not follow line");
	mdi_manual_a: assert property (resolved && st.mdi_act == 2'h0 |=>
		!st.stat[`ST_MDIX])
		else $error("manual MDI not reported");
	irq_masked_a: assert property ((ev_q & st.ien) == 16'h0000 |=>
		!irq)
		else $error("interrupt high with nothing enabled");
	page_read_clear_a: assert property (stat_read_s ##0 !page_in |=>
		!st.stat[`ST_PAGE])
		else $error("page bit survived a status read");
	link_event_a: assert property (link_up != st.stat[`ST_LINK] |=>
		ev_q[`EV_LINK])
		else $error("link change not latched");
	jabber_event_a: assert property (
		jabber_in && !st.stat[`ST_JABBER] |=> ev_q[`EV_JABBER])
		else $error("jabber rise not latched");
	ien_rsv_a: assert property (
		st.ien[7] == 1'b0 && st.ien[2] == 1'b0)
		else $error("reserved enable bit set");

endmodule : copper_phy_status_irq_enable
`default_nettype wire

// *** tb/link_partner.sv ***
// behavioural copper link partner: negotiates while go is held high
// assumes the pclk domain; dropping go takes the link down at the next pclk edge
`timescale 1ns/1ps
`default_nettype none

module link_partner (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go,
	input wire logic [1:0] speed,
	input wire logic full,
	output logic an_complete,
	output logic [1:0] line_speed,
	output logic line_full_duplex,
	output logic page_in,
	output logic link_up,
	output logic tx_pause_in,
	output logic rx_pause_in
);
	logic [2:0] cnt;
	logic go_d;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt <= 3'h0;
			go_d <= 1'b0;
		end
		else
		begin
			go_d <= go;
			cnt <= !go ? 3'h0 : (cnt == 3'h4 ? cnt : cnt + 3'h1);
		end
	end

	assign page_in = go & ~go_d;
	assign an_complete = (cnt == 3'h4);
	assign link_up = an_complete;
	// results churn until resolved, so a held field shows up
	assign line_speed = an_complete ? speed : cnt[1:0];
	assign line_full_duplex = an_complete ? full : cnt[0];
	assign tx_pause_in = an_complete | cnt[0];
	assign rx_pause_in = an_complete | cnt[0];
endmodule : link_partner

`default_nettype wire

// *** tb/copper_phy_status_irq_enable_bench.sv ***
// self-checking bench: APB register calls against status and events
// assumes link_partner drives the negotiation inputs
`timescale 1ns/1ps
`default_nettype none
`include "copper_phy_regs.svh"

module copper_phy_status_irq_enable_bench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] pstrb = 4'hF;
	logic [31:0] prdata, rd;
	logic pready, pslverr, irq, err, an_c, fdx, pg, lnk, txp, rxp, pol_off;
	logic [1:0] lspd, mdi_act;
	logic go = 1'b0;
	logic [11:0] drv = 12'h000;
	int miscompares = 0;
	int total_checks = 0;

	always #12.5 pclk = ~pclk;

	link_partner lp (.pclk(pclk), .presetn(presetn), .go(go),
		.speed(2'h1), .full(1'b1), .an_complete(an_c), .line_speed(lspd),
		.line_full_duplex(fdx), .page_in(pg), .link_up(lnk),
		.tx_pause_in(txp), .rx_pause_in(rxp));

	copper_phy_status_irq_enable dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .an_complete(an_c),
		.line_speed(lspd), .line_full_duplex(fdx), .page_in(pg),
		.link_up(lnk), .tx_pause_in(txp), .rx_pause_in(rxp),
		.auto_mdix(drv[0]), .downshift_in(drv[1]), .energy_sleep(drv[2]),
		.polarity_rev(drv[3]), .jabber_in(drv[4]), .ms_fault(drv[5]),
		.pd_fault(drv[6]), .no_common_mode(drv[7]), .an_no_link(drv[8]),
		.symbol_err(drv[9]), .false_carrier(drv[10]),
		.flp_no_link(drv[11]), .mdi_mode_active(mdi_act),
		.polarity_detect_off(pol_off));

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (n == 16)
			miscompares++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h00000000);
		check(rd, e);
	endtask : rdchk

	initial
	begin
		tick(16);
		presetn <= 1'b1;
		check({30'h0, mdi_act}, 32'h00000003);
		rdchk(`PHY_STAT1_ADDR, 32'h00008040);
		rdchk(`PHY_IEN_ADDR, 32'h00000000);
		// software keeps reserved enable bits at zero
		apb(1'b1, `PHY_IEN_ADDR, 32'h0000FF7B);
		rdchk(`PHY_IEN_ADDR, 32'h0000FF7B);
		go <= 1'b1;
		tick(8);
		rdchk(`PHY_STAT1_ADDR, 32'h00007F08);
		rdchk(`PHY_STAT1_ADDR, 32'h00006F08);
		drv <= 12'h01F;
		tick(3);
		rdchk(`PHY_STAT1_ADDR, 32'h00006F7B);
		check({31'h0, irq}, 32'h00000001);
		apb(1'b1, `PHY_IEN_ADDR, 32'h00000000);
		tick(2);
		check({31'h0, irq}, 32'h00000000);
		// write ones clears whatever the changes latched
		apb(1'b1, `PHY_EVT_ADDR, 32'h0000FFFF);
		rdchk(`PHY_EVT_ADDR, 32'h00000000);
		drv <= 12'h01B;
		tick(3);
		rdchk(`PHY_EVT_ADDR, 32'h00000010);
		apb(1'b1, `PHY_IEN_ADDR, 32'h00008000);
		// error causes pass the enable, the rest stay masked
		for (int i = 5; i < 12; i++)
		begin
			drv[i] <= 1'b1;
			tick(1);
			drv[i] <= 1'b0;
			tick(3);
			check({31'h0, irq}, {31'h0, i < 9});
			rdchk(`PHY_EVT_ADDR, i < 9 ? 32'h00008000 : i == 9 ?
				32'h00000200 : i == 10 ? 32'h00000100 : 32'h00000008);
			tick(2);
			check({31'h0, irq}, 32'h00000000);
		end
		apb(1'b1, `PHY_IEN_ADDR, 32'h00001234);
		pstrb <= 4'h1;
		apb(1'b1, `PHY_IEN_ADDR, 32'h0000FF7B);
		pstrb <= 4'hF;
		apb(1'b1, `PHY_CTRL_ADDR, 32'h00009022);
		tick(2);
		check({29'h0, pol_off, mdi_act}, 32'h00000005);
		rdchk(`PHY_IEN_ADDR, 32'h00001230);
		rdchk(`PHY_STAT1_ADDR, 32'h00006F69);
		go <= 1'b0;
		tick(3);
		apb(1'b0, `PHY_STAT1_ADDR, 32'h00000000);
		check(rd & 32'h00000C08, 32'h00000000);
		apb(1'b1, `PHY_CTRL_ADDR, 32'h00000020);
		tick(3);
		apb(1'b0, `PHY_STAT1_ADDR, 32'h00000000);
		check(rd & 32'h0000C800, 32'h00000800);
		// manual MDI after a soft reset with negotiation off
		apb(1'b1, `PHY_CTRL_ADDR, 32'h00008000);
		rdchk(`PHY_STAT1_ADDR, 32'h00000823);
		check({29'h0, pol_off, mdi_act}, 32'h00000000);
		apb(1'b0, 8'h50, 32'h00000000);
		check({err, rd[30:0]}, 32'h80000000);
		// quiet inputs, so no event is pending across the release
		drv <= 12'h000;
		presetn <= 1'b0;
		tick(2);
		presetn <= 1'b1;
		check({30'h0, mdi_act}, 32'h00000003);
		rdchk(`PHY_IEN_ADDR, 32'h00000000);
		rdchk(`PHY_STAT1_ADDR, 32'h00008040);
		tally_and_finish;
	end

	initial
	begin
		#200000;
		miscompares++;
		tally_and_finish;
	end
endmodule : copper_phy_status_irq_enable_bench

`default_nettype wire
